//--- shared/dlc_params.svh
// Constants of the DDR3 leveling and calibration controller
`ifndef DLC_PARAMS_SVH
`define DLC_PARAMS_SVH
`define DLC_LANES      2
`define DLC_DQ_W       16
`define DLC_BURST      8
`define DLC_ZQCL_CYC   512
`define DLC_ZQCS_CYC   64
`define DLC_WR_LAT     4
`define DLC_RD_LAT     6
`define DLC_TAP_MAX    4'hf
`define DLC_WR_END     (`DLC_WR_LAT + `DLC_BURST + 15)
`define DLC_RD_END     (`DLC_RD_LAT + `DLC_BURST + 15 + 2)
`define DLC_WLP_END    (15 + 4)
`define DLC_FIFO_DEPTH 16
`define DLC_ADDR_W     33
`define DLC_MAP_8G     33
`define DLC_MAP_2G     31
`define DLC_RST_HOLD   1024
`define DLC_MAX_MTS    1600
`define DLC_MPR_EVEN   8'h00
`define DLC_MPR_ODD    8'hff
`define DLC_ECC_M1     13'h0aaa
`define DLC_ECC_M2     13'h0ccc
`define DLC_ECC_M4     13'h10f0
`define DLC_ECC_M8     13'h1f00
`endif

//--- shared/dlc_pkg.sv
// Types of the DDR3 leveling and calibration controller
`include "dlc_params.svh"
package dlc_pkg;
	typedef enum logic [3:0] {
		ST_RST = 4'h0, ST_WAIT = 4'h1, ST_WL = 4'h2, ST_RL = 4'h3,
		ST_IDLE = 4'h4, ST_WCOL = 4'h5, ST_ROUT = 4'h6
	} dlc_st_t;
	typedef enum logic [2:0] {
		OP_ZQCL = 3'h0, OP_ZQCS = 3'h1, OP_WR = 3'h2,
		OP_RD = 3'h3, OP_WLP = 3'h4, OP_RLP = 3'h5
	} dlc_op_t;
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0, CMD_ZQCL = 4'h1, CMD_ZQCS = 4'h2, CMD_PREA = 4'h3,
		CMD_WR = 4'h4, CMD_RD = 4'h5, CMD_MPR_RD = 4'h6, CMD_WLEV = 4'h7
	} dlc_cmd_t;
	typedef enum logic {L_IDLE = 1'b0, L_RUN = 1'b1} dlc_lst_t;
	typedef logic [`DLC_LANES-1:0][3:0] dlc_dly_t;
	typedef struct packed {
		logic req_s1, req_s2, req_s3, ack;
		dlc_lst_t st;
		logic [9:0] cnt;
		dlc_cmd_t cmd;
		logic [2:0] ba;
		logic [14:0] a;
		logic [`DLC_DQ_W-1:0] dq_s1, dq_s2, dq_o;
		logic dq_oe;
		logic [`DLC_LANES-1:0] dqs_o, dqs_oe, wl;
		logic [`DLC_BURST*`DLC_DQ_W-1:0] rbuf;
	} dlc_lnk_t;
	typedef struct packed {
		dlc_st_t st, ret;
		dlc_op_t op;
		logic req, ack_s1, ack_s2, ack_s3;
		logic lane, wl_prev, wl_fail, rl_fail, done, zq_pend, aok;
		logic [3:0] tap;
		dlc_dly_t wdly, rdly;
		logic [15:0] cnt, zq_tmr;
		logic [2:0] idx, ba;
		logic [9:0] col;
		logic [`DLC_BURST*`DLC_DQ_W-1:0] wbuf, rbuf;
		logic [`DLC_LANES-1:0] wls;
		logic mem_rst_b, rd_valid, sbe, dbe, addr_err, cmd_rdy;
		logic [7:0] rd_data;
	} dlc_ctl_t;
endpackage

//--- rtl/dlc_ctrl.sv
// DDR3 leveling, calibration and ECC data path with write FIFO
`timescale 1ns/1ps
`include "dlc_params.svh"

module dlc_fifo #(
	parameter int unsigned W = 8,
	parameter int unsigned D = 16
) (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_b,
	// Fill side
	input  wire logic                   i_valid,
	input  wire logic [W-1:0]           i_data,
	output logic                        o_ready,
	// Drain side
	output logic                        o_valid,
	output logic [W-1:0]                o_data,
	input  wire logic                   i_ready,
	output logic [$clog2(D):0]          o_count
);
	localparam int unsigned AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp, rp;
		logic [AW:0] cnt;
		logic in_rdy;
	} dlc_fifo_st_t;
	localparam dlc_fifo_st_t RST = '{mem: '0, wp: '0, rp: '0, cnt: '0, in_rdy: 1'b1};
	dlc_fifo_st_t r, n;
	logic push, pop;

	always_comb begin
		n = r;
		push = i_valid & r.in_rdy;
		pop = i_ready & (r.cnt != '0);
		if (push) begin
			n.mem[r.wp] = i_data;
			n.wp = r.wp + AW'(1);
		end
		if (pop) begin
			n.rp = r.rp + AW'(1);
		end
		n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		n.in_rdy = n.cnt != (AW+1)'(D);
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= RST;
		end else begin
			r <= n;
		end
	end

	assign o_ready = r.in_rdy;
	assign o_valid = r.cnt != '0;
	assign o_data = r.mem[r.rp];
	assign o_count = r.cnt;
endmodule // dlc_fifo

// Memory-facing logic on the memory clock
module dlc_link (
	// Clock and reset
	input  wire logic                   i_ck,
	input  wire logic                   i_rst_b,
	// Request from controller
	input  wire logic                   i_req_tgl,
	input  dlc_pkg::dlc_op_t            i_op,
	input  wire logic                   i_lane,
	input  wire logic [3:0]             i_tap,
	input  wire logic [9:0]             i_col,
	input  wire logic [2:0]             i_ba,
	input  wire logic [127:0]           i_wdata,
	input  dlc_pkg::dlc_dly_t           i_wdly,
	input  dlc_pkg::dlc_dly_t           i_rdly,
	// Answer to controller
	output logic                        o_ack_tgl,
	output logic [127:0]                o_rdata,
	output logic [`DLC_LANES-1:0]       o_wl,
	// Memory pins
	output logic [3:0]                  o_mem_cmd,
	output logic [2:0]                  o_mem_ba,
	output logic [14:0]                 o_mem_a,
	output logic [`DLC_DQ_W-1:0]        o_dq_o,
	output logic                        o_dq_oe,
	input  wire logic [`DLC_DQ_W-1:0]   i_dq_i,
	output logic [`DLC_LANES-1:0]       o_dqs_o,
	output logic [`DLC_LANES-1:0]       o_dqs_oe
);
	dlc_pkg::dlc_lnk_t r, n;
	logic [`DLC_LANES-1:0][2:0] wbeat, rbeat;
	logic [`DLC_LANES-1:0] whit, rhit;
	logic [9:0] wb;
	logic fin;

	for (genvar l = 0; l < `DLC_LANES; l++) begin : g_lane
		logic [9:0] wo, ro;
		logic [3:0] rd;
		assign rd = (i_op == dlc_pkg::OP_RLP) ? i_tap : i_rdly[l];
		assign wo = r.cnt - 10'(`DLC_WR_LAT) - {6'h0, i_wdly[l]};
		assign ro = r.cnt - 10'(`DLC_RD_LAT) - {6'h0, rd};
		assign whit[l] = wo < 10'(`DLC_BURST);
		assign rhit[l] = ro < 10'(`DLC_BURST);
		assign wbeat[l] = wo[2:0];
		assign rbeat[l] = ro[2:0];
	end

	always_comb begin
		n = r;
		fin = 1'b0;
		wb = r.cnt - 10'(`DLC_WR_LAT);
		n.req_s1 = i_req_tgl;
		n.req_s2 = r.req_s1;
		n.req_s3 = r.req_s2;
		n.dq_s1 = i_dq_i;
		n.dq_s2 = r.dq_s1;
		n.cmd = dlc_pkg::CMD_NOP;
		n.dq_oe = 1'b0;
		n.dqs_oe = '0;
		n.dqs_o = '0;
		case (r.st)
			dlc_pkg::L_IDLE: begin
				if (r.req_s2 != r.req_s3) begin
					n.st = dlc_pkg::L_RUN;
					n.cnt = '0;
					n.ba = i_ba;
					n.a = {5'h0, i_col};
					case (i_op)
						dlc_pkg::OP_ZQCL: n.cmd = dlc_pkg::CMD_ZQCL;
						dlc_pkg::OP_ZQCS: n.cmd = dlc_pkg::CMD_PREA;
						dlc_pkg::OP_WR: n.cmd = dlc_pkg::CMD_WR;
						dlc_pkg::OP_RD: n.cmd = dlc_pkg::CMD_RD;
						dlc_pkg::OP_RLP: n.cmd = dlc_pkg::CMD_MPR_RD;
						default: n.cmd = dlc_pkg::CMD_WLEV;
					endcase
				end
			end
			dlc_pkg::L_RUN: begin
				n.cnt = r.cnt + 10'h001;
				case (i_op)
					dlc_pkg::OP_ZQCL: fin = r.cnt == 10'(`DLC_ZQCL_CYC - 1);
					dlc_pkg::OP_ZQCS: begin
						if (r.cnt == 10'h000) begin
							n.cmd = dlc_pkg::CMD_ZQCS;
						end
						fin = r.cnt == 10'(`DLC_ZQCS_CYC);
					end
					dlc_pkg::OP_WR: begin
						if (wb < 10'(`DLC_BURST)) begin
							n.dq_o = i_wdata[{wb[2:0], 4'h0} +: `DLC_DQ_W];
							n.dq_oe = 1'b1;
						end
						for (int l = 0; l < `DLC_LANES; l++) begin
							n.dqs_oe[l] = whit[l];
							n.dqs_o[l] = whit[l] & ~wbeat[l][0];
						end
						fin = r.cnt == 10'(`DLC_WR_END);
					end
					dlc_pkg::OP_WLP: begin
						if (r.cnt == {6'h0, i_tap}) begin
							n.dqs_oe[i_lane] = 1'b1;
							n.dqs_o[i_lane] = 1'b1;
						end
						fin = r.cnt == 10'(`DLC_WLP_END);
						if (fin) begin
							for (int l = 0; l < `DLC_LANES; l++) begin
								n.wl[l] = r.dq_s2[l*8];
							end
						end
					end
					default: begin
						for (int l = 0; l < `DLC_LANES; l++) begin
							if (rhit[l]) begin
								n.rbuf[7'({rbeat[l], 4'h0}) + 7'(l*8) +: 8] = r.dq_s2[l*8 +: 8];
							end
						end
						fin = r.cnt == 10'(`DLC_RD_END);
					end
				endcase
				if (fin) begin
					n.st = dlc_pkg::L_IDLE;
					n.ack = ~r.ack;
				end
			end
			default: n.st = dlc_pkg::L_IDLE;
		endcase
	end

	always_ff @(posedge i_ck or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_ack_tgl = r.ack;
	assign o_rdata = r.rbuf;
	assign o_wl = r.wl;
	assign o_mem_cmd = r.cmd;
	assign o_mem_ba = r.ba;
	assign o_mem_a = r.a;
	assign o_dq_o = r.dq_o;
	assign o_dq_oe = r.dq_oe;
	assign o_dqs_o = r.dqs_o;
	assign o_dqs_oe = r.dqs_oe;
endmodule // dlc_link

module dlc_ctrl #(
	parameter int unsigned MAP_LOG2 = `DLC_MAP_8G,
	parameter int unsigned RST_HOLD = `DLC_RST_HOLD
) (
	// Clocks and reset
	input  wire logic                   i_mclk,
	input  wire logic                   i_ck,
	input  wire logic                   i_rst_b,
	// Write stream
	input  wire logic                   i_wr_valid,
	input  wire logic [7:0]             i_wr_data,
	input  wire logic [`DLC_ADDR_W-1:0] i_wr_addr,
	output logic                        o_wr_ready,
	// Read requests and data
	input  wire logic                   i_rd_req,
	input  wire logic [`DLC_ADDR_W-1:0] i_rd_addr,
	output logic                        o_cmd_ready,
	output logic                        o_rd_valid,
	output logic [7:0]                  o_rd_data,
	output logic                        o_ecc_sbe,
	output logic                        o_ecc_dbe,
	output logic                        o_addr_err,
	// Calibration
	input  wire logic [15:0]            i_zqcs_interval,
	output logic                        o_cal_done,
	output logic                        o_wl_fail,
	output logic                        o_rl_fail,
	output dlc_pkg::dlc_dly_t           o_wdly,
	output dlc_pkg::dlc_dly_t           o_rdly,
	// Memory pins
	output logic                        o_mem_rst_b,
	output logic [3:0]                  o_mem_cmd,
	output logic [2:0]                  o_mem_ba,
	output logic [14:0]                 o_mem_a,
	output logic [`DLC_DQ_W-1:0]        o_dq_o,
	output logic                        o_dq_oe,
	input  wire logic [`DLC_DQ_W-1:0]   i_dq_i,
	output logic [`DLC_LANES-1:0]       o_dqs_o,
	output logic [`DLC_LANES-1:0]       o_dqs_oe
);
	dlc_pkg::dlc_ctl_t r, n;
	logic ack_tgl, f_valid, f_ready, pop, nxt, match;
	logic [127:0] l_rdata;
	logic [`DLC_LANES-1:0] l_wl;
	logic [7:0] f_data;
	logic [4:0] f_cnt;
	logic [9:0] dec;

	function automatic logic [12:0] ecc_enc(input logic [7:0] d);
		logic [12:0] c;
		c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 3'h0};
		c[1] = ^(c & `DLC_ECC_M1);
		c[2] = ^(c & `DLC_ECC_M2);
		c[4] = ^(c & `DLC_ECC_M4);
		c[8] = ^(c & `DLC_ECC_M8);
		c[0] = ^c;
		return c;
	endfunction

	// Returns {double, single, data}
	function automatic logic [9:0] ecc_dec(input logic [12:0] c);
		logic [3:0] s;
		logic [12:0] f;
		logic par;
		logic ok;
		s = {^(c & `DLC_ECC_M8), ^(c & `DLC_ECC_M4), ^(c & `DLC_ECC_M2), ^(c & `DLC_ECC_M1)};
		par = ^c;
		f = c;
		ok = par && s <= 4'hc;
		if (ok) begin
			f[s] = ~c[s];
		end
		return {(!par && s != 4'h0) || (par && !ok), ok, f[12:9], f[7:5], f[3]};
	endfunction

	function automatic logic in_map(input logic [`DLC_ADDR_W-1:0] a);
		return (a >> MAP_LOG2) == '0;
	endfunction

	function automatic dlc_pkg::dlc_ctl_t launch(input dlc_pkg::dlc_ctl_t s,
			input dlc_pkg::dlc_op_t op, input dlc_pkg::dlc_st_t ret);
		s.op = op;
		s.req = ~s.req;
		s.ret = ret;
		s.st = dlc_pkg::ST_WAIT;
		return s;
	endfunction

	dlc_fifo #(.W(8), .D(`DLC_FIFO_DEPTH)) u_fifo (
		.i_clk   (i_mclk),
		.i_rst_b (i_rst_b),
		.i_valid (i_wr_valid),
		.i_data  (i_wr_data),
		.o_ready (o_wr_ready),
		.o_valid (f_valid),
		.o_data  (f_data),
		.i_ready (pop),
		.o_count (f_cnt)
	);

	// Link side runs on its own clock at any rate up to the ceiling
	dlc_link u_link (
		.i_ck      (i_ck),
		.i_rst_b   (i_rst_b),
		.i_req_tgl (r.req),
		.i_op      (r.op),
		.i_lane    (r.lane),
		.i_tap     (r.tap),
		.i_col     (r.col),
		.i_ba      (r.ba),
		.i_wdata   (r.wbuf),
		.i_wdly    (r.wdly),
		.i_rdly    (r.rdly),
		.o_ack_tgl (ack_tgl),
		.o_rdata   (l_rdata),
		.o_wl      (l_wl),
		.o_mem_cmd (o_mem_cmd),
		.o_mem_ba  (o_mem_ba),
		.o_mem_a   (o_mem_a),
		.o_dq_o    (o_dq_o),
		.o_dq_oe   (o_dq_oe),
		.i_dq_i    (i_dq_i),
		.o_dqs_o   (o_dqs_o),
		.o_dqs_oe  (o_dqs_oe)
	);

	always_comb begin
		n = r;
		pop = 1'b0;
		nxt = 1'b0;
		match = 1'b0;
		dec = '0;
		n.ack_s1 = ack_tgl;
		n.ack_s2 = r.ack_s1;
		n.ack_s3 = r.ack_s2;
		n.rd_valid = 1'b0;
		n.sbe = 1'b0;
		n.dbe = 1'b0;
		n.addr_err = 1'b0;
		case (r.st)
			dlc_pkg::ST_RST: begin
				if (r.cnt == 16'(RST_HOLD - 1)) begin
					n.cnt = '0;
					n.mem_rst_b = 1'b1;
					n = launch(n, dlc_pkg::OP_ZQCL, dlc_pkg::ST_WL);
				end else begin
					n.cnt = r.cnt + 16'h0001;
				end
			end
			dlc_pkg::ST_WAIT: begin
				if (r.ack_s2 != r.ack_s3) begin
					n.rbuf = l_rdata;
					n.wls = l_wl;
					n.st = r.ret;
				end
			end
			dlc_pkg::ST_WL: begin
				if (r.op != dlc_pkg::OP_WLP) begin
					n.lane = 1'b0;
					n.tap = 4'h0;
					n.wl_prev = 1'b1;
				end else begin
					n.wl_prev = r.wls[r.lane];
					if (!r.wl_prev && r.wls[r.lane]) begin
						n.wdly[r.lane] = r.tap;
						nxt = 1'b1;
					end else if (r.tap == `DLC_TAP_MAX) begin
						n.wl_fail = 1'b1;
						nxt = 1'b1;
					end else begin
						n.tap = r.tap + 4'h1;
					end
				end
				if (nxt && r.lane) begin
					n.lane = 1'b0;
					n.tap = 4'h0;
					n = launch(n, dlc_pkg::OP_RLP, dlc_pkg::ST_RL);
				end else begin
					if (nxt) begin
						n.lane = 1'b1;
						n.tap = 4'h0;
						n.wl_prev = 1'b1;
					end
					n = launch(n, dlc_pkg::OP_WLP, dlc_pkg::ST_WL);
				end
			end
			dlc_pkg::ST_RL: begin
				match = r.rbuf[7'(r.lane)*7'h08 +: 8] == `DLC_MPR_EVEN &&
					r.rbuf[7'h10 + 7'(r.lane)*7'h08 +: 8] == `DLC_MPR_ODD;
				if (match) begin
					n.rdly[r.lane] = r.tap;
					nxt = 1'b1;
				end else if (r.tap == `DLC_TAP_MAX) begin
					n.rl_fail = 1'b1;
					nxt = 1'b1;
				end else begin
					n.tap = r.tap + 4'h1;
				end
				if (nxt && r.lane) begin
					n.done = 1'b1;
					n.st = dlc_pkg::ST_IDLE;
				end else begin
					if (nxt) begin
						n.lane = 1'b1;
						n.tap = 4'h0;
					end
					n = launch(n, dlc_pkg::OP_RLP, dlc_pkg::ST_RL);
				end
			end
			dlc_pkg::ST_IDLE: begin
				n.idx = 3'h0;
				if (i_rd_req) begin
					n.col = i_rd_addr[12:3];
					n.ba = i_rd_addr[15:13];
					if (in_map(i_rd_addr)) begin
						n = launch(n, dlc_pkg::OP_RD, dlc_pkg::ST_ROUT);
					end else begin
						n.addr_err = 1'b1;
					end
				end else if (f_cnt >= 5'(`DLC_BURST)) begin
					n.col = i_wr_addr[12:3];
					n.ba = i_wr_addr[15:13];
					n.aok = in_map(i_wr_addr);
					n.st = dlc_pkg::ST_WCOL;
				end else if (r.zq_pend) begin
					n.zq_pend = 1'b0;
					n = launch(n, dlc_pkg::OP_ZQCS, dlc_pkg::ST_IDLE);
				end
			end
			dlc_pkg::ST_WCOL: begin
				pop = f_valid;
				n.wbuf[{r.idx, 4'h0} +: `DLC_DQ_W] = {3'h0, ecc_enc(f_data)};
				n.idx = r.idx + 3'h1;
				if (r.idx == 3'h7) begin
					if (r.aok) begin
						n = launch(n, dlc_pkg::OP_WR, dlc_pkg::ST_IDLE);
					end else begin
						n.addr_err = 1'b1;
						n.st = dlc_pkg::ST_IDLE;
					end
				end
			end
			dlc_pkg::ST_ROUT: begin
				dec = ecc_dec(r.rbuf[{r.idx, 4'h0} +: 13]);
				n.rd_valid = 1'b1;
				n.rd_data = dec[7:0];
				n.sbe = dec[8];
				n.dbe = dec[9];
				n.idx = r.idx + 3'h1;
				if (r.idx == 3'h7) begin
					n.st = dlc_pkg::ST_IDLE;
				end
			end
			default: n.st = dlc_pkg::ST_RST;
		endcase
		if (r.done) begin
			if (r.zq_tmr >= i_zqcs_interval) begin
				n.zq_tmr = '0;
				n.zq_pend = 1'b1;
			end else begin
				n.zq_tmr = r.zq_tmr + 16'h0001;
			end
		end
		n.cmd_rdy = n.st == dlc_pkg::ST_IDLE;
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_cmd_ready = r.cmd_rdy;
	assign o_rd_valid = r.rd_valid;
	assign o_rd_data = r.rd_data;
	assign o_ecc_sbe = r.sbe;
	assign o_ecc_dbe = r.dbe;
	assign o_addr_err = r.addr_err;
	assign o_cal_done = r.done;
	assign o_wl_fail = r.wl_fail;
	assign o_rl_fail = r.rl_fail;
	assign o_wdly = r.wdly;
	assign o_rdly = r.rdly;
	assign o_mem_rst_b = r.mem_rst_b;
endmodule // dlc_ctrl

//--- tb/dlc_chk_asserts.sv
// Assertion checker for the leveling and calibration controller
`timescale 1ns/1ps
`include "dlc_params.svh"
module dlc_chk #(
	parameter int unsigned MAP_LOG2 = `DLC_MAP_8G,
	parameter int unsigned RST_HOLD = `DLC_RST_HOLD
) (
	// Clocks and reset
	input wire logic                   i_mclk,
	input wire logic                   i_ck,
	input wire logic                   i_rst_b,
	// Read side
	input wire logic                   i_rd_req,
	input wire logic [`DLC_ADDR_W-1:0] i_rd_addr,
	input wire logic                   o_cmd_ready,
	input wire logic                   o_rd_valid,
	input wire logic                   o_addr_err,
	// Memory pins
	input wire logic                   o_mem_rst_b,
	input wire logic [3:0]             o_mem_cmd,
	input wire logic                   o_dq_oe
);
	logic [15:0] hold_reg;
	logic [9:0]  gap_reg;
	logic [3:0]  last_reg;
	logic        seen_reg;
	// Cycles of memory reset since release
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b)
			hold_reg <= 16'h0;
		else if (!o_mem_rst_b)
			hold_reg <= hold_reg + 16'h1;
	end
	// Idle link cycles since the last command
	always_ff @(posedge i_ck or negedge i_rst_b) begin
		if (!i_rst_b) begin
			gap_reg <= 10'h0;
			last_reg <= 4'h0;
			seen_reg <= 1'b0;
		end else if (o_mem_cmd != 4'h0) begin
			gap_reg <= 10'h0;
			last_reg <= o_mem_cmd;
			seen_reg <= 1'b1;
		end else if (gap_reg != 10'h3ff)
			gap_reg <= gap_reg + 10'h1;
	end
	property p_rst_hold;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(!o_mem_rst_b |-> hold_reg <= RST_HOLD + 4) and
		($rose(o_mem_rst_b) |-> hold_reg + 2 >= RST_HOLD);
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("memory reset hold wrong");
	property p_zqcl_first;
		@(posedge i_ck) disable iff (!i_rst_b)
		o_mem_cmd != 4'h0 && !seen_reg |-> o_mem_cmd == dlc_pkg::CMD_ZQCL;
	endproperty
	a_zqcl_first: assert property (p_zqcl_first) else $error("first command not ZQCL");
	property p_zqcl_gap;
		@(posedge i_ck) disable iff (!i_rst_b)
		o_mem_cmd != 4'h0 && last_reg == dlc_pkg::CMD_ZQCL |-> gap_reg >= 10'h1ff;
	endproperty
	a_zqcl_gap: assert property (p_zqcl_gap) else $error("command too soon after ZQCL");
	property p_zqcs_gap;
		@(posedge i_ck) disable iff (!i_rst_b)
		o_mem_cmd != 4'h0 && last_reg == dlc_pkg::CMD_ZQCS |-> gap_reg >= 10'h3f;
	endproperty
	a_zqcs_gap: assert property (p_zqcs_gap) else $error("command too soon after ZQCS");
	property p_zqcs_prea;
		@(posedge i_ck) disable iff (!i_rst_b)
		o_mem_cmd == dlc_pkg::CMD_ZQCS |-> last_reg == dlc_pkg::CMD_PREA && gap_reg == 10'h0;
	endproperty
	a_zqcs_prea: assert property (p_zqcs_prea) else $error("ZQCS without precharge");
	property p_rd_burst;
		@(posedge i_mclk) disable iff (!i_rst_b)
		$rose(o_rd_valid) |-> o_rd_valid [*8] ##1 !o_rd_valid;
	endproperty
	a_rd_burst: assert property (p_rd_burst) else $error("read burst not eight beats");
	property p_wr_burst;
		@(posedge i_ck) disable iff (!i_rst_b)
		o_mem_cmd == dlc_pkg::CMD_WR |-> ##5 o_dq_oe [*8] ##1 !o_dq_oe;
	endproperty
	a_wr_burst: assert property (p_wr_burst) else $error("write burst not eight beats");
	property p_addr_err;
		@(posedge i_mclk) disable iff (!i_rst_b)
		i_rd_req && o_cmd_ready |=> o_addr_err == (($past(i_rd_addr) >> MAP_LOG2) != 0);
	endproperty
	a_addr_err: assert property (p_addr_err) else $error("address range flag wrong");
endmodule // dlc_chk

bind dlc_ctrl dlc_chk #(.MAP_LOG2(MAP_LOG2), .RST_HOLD(RST_HOLD)) u_dlc_chk (
	.i_mclk(i_mclk), .i_ck(i_ck), .i_rst_b(i_rst_b), .i_rd_req(i_rd_req),
	.i_rd_addr(i_rd_addr), .o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid),
	.o_addr_err(o_addr_err), .o_mem_rst_b(o_mem_rst_b), .o_mem_cmd(o_mem_cmd),
	.o_dq_oe(o_dq_oe)
);

//--- tb/dlc_mem_model.sv
// Behavioural pair of x8 memory devices on the controller pins
`timescale 1ns/1ps
module dlc_mem_model #(
	parameter int W0 = 3,
	parameter int W1 = 5,
	parameter int R0 = 1,
	parameter int R1 = 2
) (
	// Clock and memory reset
	input  wire logic        i_ck,
	input  wire logic        i_rst_b,
	// Command and address
	input  wire logic [3:0]  i_cmd,
	input  wire logic [2:0]  i_ba,
	input  wire logic [14:0] i_a,
	// Data, strobes and ordered bit errors
	input  wire logic [15:0] i_dq,
	input  wire logic        i_dq_oe,
	input  wire logic [1:0]  i_dqs,
	input  wire logic [1:0]  i_dqs_oe,
	input  wire logic [1:0]  i_flip,
	output logic      [15:0] o_dq
);
	logic [15:0] mem [8192][8];
	logic [3:0]  cmd;
	logic [12:0] idx;
	logic [1:0]  lvl;
	int          cnt = 0;
	int          k;
	always @(posedge i_ck) begin
		cnt <= cnt + 1;
		o_dq <= ~o_dq;
		if (!i_rst_b) begin
			cmd <= 4'h0;
			lvl <= 2'h0;
			o_dq <= 16'h5a5a;
		end else if (i_cmd != 4'h0) begin
			cmd <= i_cmd;
			idx <= {i_ba, i_a[9:0]};
			cnt <= 1;
		end
		if (cmd == 4'h4 && i_dq_oe && cnt >= 5 && cnt <= 12)
			mem[idx][cnt-5] <= i_dq;
		for (int l = 0; l < 2; l++) begin
			k = cnt - 3 - (l ? R1 : R0);
			if (cmd == 4'h7 && i_dqs_oe[l] && i_dqs[l])
				lvl[l] <= cnt > (l ? W1 : W0);
			if (cmd == 4'h7)
				o_dq[l*8+:8] <= {7'h0, lvl[l]};
			if ((cmd == 4'h5 || cmd == 4'h6) && k >= 0 && k < 8)
				o_dq[l*8+:8] <= (cmd == 4'h6) ? {8{k[0]}} :
					mem[idx][k][l*8+:8] ^ ((l == 0 && k == 2) ?
					{3'h0, i_flip[1], |i_flip, 3'h0} : 8'h0);
		end
	end
endmodule // dlc_mem_model

//--- tb/tb_top.sv
// Self-checking bench for the leveling and calibration controller
`timescale 1ns/1ps
`include "dlc_params.svh"
module tb_top;
	logic                   i_mclk = 1'b0;
	logic                   i_ck = 1'b0;
	logic                   i_rst_b = 1'b0;
	logic                   i_wr_valid = 1'b0;
	logic [7:0]             i_wr_data = 8'h0;
	logic [`DLC_ADDR_W-1:0] i_wr_addr = 33'h0;
	logic                   i_rd_req = 1'b0;
	logic [`DLC_ADDR_W-1:0] i_rd_addr = 33'h0;
	logic [1:0]             flip = 2'h0;
	logic [15:0]            zq_ivl = 16'h2000;
	logic                   o_wr_ready, o_cmd_ready, o_rd_valid, o_ecc_sbe, o_ecc_dbe;
	logic                   o_addr_err, o_cal_done, o_wl_fail, o_rl_fail, o_mem_rst_b;
	logic                   o_dq_oe;
	logic [7:0]             o_rd_data;
	dlc_pkg::dlc_dly_t      o_wdly, o_rdly;
	logic [3:0]             o_mem_cmd;
	logic [2:0]             o_mem_ba;
	logic [14:0]            o_mem_a;
	logic [15:0]            o_dq_o, mem_dq, dq_w;
	logic [1:0]             o_dqs_o, o_dqs_oe;
	logic [63:0]            rd_d;
	logic [7:0]             rd_sb, rd_db;
	int                     bad_count = 0;
	int                     checks_done = 0;
	// Data wire seen by both parties
	assign dq_w = o_dq_oe ? o_dq_o : mem_dq;
	always #2 i_mclk = ~i_mclk;
	always #62.5 i_ck = ~i_ck;
	dlc_ctrl #(.MAP_LOG2(`DLC_MAP_2G), .RST_HOLD(16)) u_dlc_ctrl (
		.i_mclk(i_mclk), .i_ck(i_ck), .i_rst_b(i_rst_b), .i_wr_valid(i_wr_valid),
		.i_wr_data(i_wr_data), .i_wr_addr(i_wr_addr), .o_wr_ready(o_wr_ready),
		.i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr), .o_cmd_ready(o_cmd_ready),
		.o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_ecc_sbe(o_ecc_sbe),
		.o_ecc_dbe(o_ecc_dbe), .o_addr_err(o_addr_err), .i_zqcs_interval(zq_ivl),
		.o_cal_done(o_cal_done), .o_wl_fail(o_wl_fail), .o_rl_fail(o_rl_fail),
		.o_wdly(o_wdly), .o_rdly(o_rdly), .o_mem_rst_b(o_mem_rst_b),
		.o_mem_cmd(o_mem_cmd), .o_mem_ba(o_mem_ba), .o_mem_a(o_mem_a),
		.o_dq_o(o_dq_o), .o_dq_oe(o_dq_oe), .i_dq_i(dq_w), .o_dqs_o(o_dqs_o),
		.o_dqs_oe(o_dqs_oe)
	);
	dlc_mem_model u_dlc_mem_model (
		.i_ck(i_ck), .i_rst_b(o_mem_rst_b), .i_cmd(o_mem_cmd), .i_ba(o_mem_ba),
		.i_a(o_mem_a), .i_dq(dq_w), .i_dq_oe(o_dq_oe), .i_dqs(o_dqs_o),
		.i_dqs_oe(o_dqs_oe), .i_flip(flip), .o_dq(mem_dq)
	);
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic [63:0] exp8(input logic [7:0] b);
		for (int k = 0; k < 8; k++)
			exp8[k*8+:8] = b + 8'(k);
	endfunction
	task automatic push(input logic [7:0] d);
		i_wr_data <= d;
		i_wr_valid <= 1'b1;
		@(posedge i_mclk);
		while (o_wr_ready !== 1'b1) @(posedge i_mclk);
	endtask
	// Wait until the controller stays idle for 16 cycles
	task automatic settle;
		int n = 0;
		while (n < 16) begin
			@(posedge i_mclk);
			n = (o_cmd_ready === 1'b1) ? n + 1 : 0;
		end
	endtask
	task automatic wr8(input logic [32:0] a, input logic [7:0] b);
		i_wr_addr <= a;
		for (int k = 0; k < 8; k++)
			push(b + 8'(k));
		i_wr_valid <= 1'b0;
		settle();
	endtask
	task automatic take(input logic [32:0] a);
		i_rd_addr <= a;
		i_rd_req <= 1'b1;
		@(posedge i_mclk);
		while (o_cmd_ready !== 1'b1) @(posedge i_mclk);
		i_rd_req <= 1'b0;
	endtask
	task automatic rd8(input logic [32:0] a, input logic [1:0] f);
		int n = 0;
		flip <= f;
		take(a);
		while (n < 8) begin
			@(posedge i_mclk);
			if (o_rd_valid === 1'b1) begin
				rd_d[n*8+:8] = o_rd_data;
				rd_sb[n] = o_ecc_sbe;
				rd_db[n] = o_ecc_dbe;
				n++;
			end
		end
	endtask
	task automatic t_cal;
		while (o_cmd_ready !== 1'b1) @(posedge i_mclk);
		chk("cal_done", o_cal_done, 64'h1);
		chk("wdly", o_wdly, {4'h5, 4'h3});
		chk("rdly", o_rdly, {4'h2, 4'h1});
		chk("lvl_fail", {o_wl_fail, o_rl_fail}, 64'h0);
		chk("mem_rst", o_mem_rst_b, 64'h1);
	endtask
	task automatic t_wr_rd;
		logic [32:0] a;
		for (int i = 0; i < 2; i++) begin
			a = i ? 33'h0_7fff_fff8 : 33'h0_0000_2460;
			wr8(a, 8'h10);
			rd8(a, 2'h0);
			chk("rd_data", rd_d, exp8(8'h10));
			chk("rd_flags", {rd_sb, rd_db}, 64'h0);
			chk("mem_addr", {o_mem_ba, o_mem_a}, {a[15:13], 5'h0, a[12:3]});
		end
	endtask
	// Fill the buffer while a read keeps the link busy
	task automatic t_fill;
		take(33'h0_0000_2460);
		i_wr_addr <= 33'h0_0000_0040;
		for (int k = 0; k < 16; k++)
			push(8'h20 + 8'(k));
		i_wr_data <= 8'h55;
		@(posedge i_mclk);
		chk("fifo_full", o_wr_ready, 64'h0);
		i_wr_valid <= 1'b0;
		settle();
		rd8(33'h0_0000_0040, 2'h0);
		chk("fifo_data", rd_d, exp8(8'h28));
	endtask
	task automatic t_ecc;
		rd8(33'h0_0000_2460, 2'h1);
		chk("sbe_data", rd_d, exp8(8'h10));
		chk("sbe_flags", {rd_sb, rd_db}, {8'h04, 8'h00});
		rd8(33'h0_0000_2460, 2'h2);
		chk("dbe_flags", {rd_sb, rd_db}, {8'h00, 8'h04});
		flip <= 2'h0;
	endtask
	task automatic t_addr_err;
		int n = 0;
		take(33'h0_8000_0000);
		@(posedge i_mclk);
		chk("addr_err", o_addr_err, 64'h1);
		repeat (1200) begin
			@(posedge i_mclk);
			if (o_rd_valid === 1'b1)
				n++;
		end
		chk("dropped_beats", n, 64'h0);
	endtask
	task automatic t_zqcs;
		zq_ivl <= 16'h0400;
		while (o_mem_cmd !== dlc_pkg::CMD_ZQCS) @(posedge i_mclk);
		chk("zq_busy", o_cmd_ready, 64'h0);
	endtask
	// Watchdog well beyond leveling plus all scenarios
	initial begin
		#360_000;
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge i_ck);
		@(posedge i_mclk);
		i_rst_b <= 1'b1;
		t_cal();
		t_wr_rd();
		t_fill();
		t_ecc();
		t_addr_err();
		t_zqcs();
		stop_test();
	end
endmodule // tb_top
